// *** pkg/sensor_consts.svh ***
// constants for the single-wire temperature sensor and its bus master
// assumes a 250 MHz system clock; times are in microseconds
`ifndef SENSOR_CONSTS_SVH
`define SENSOR_CONSTS_SVH

// ========================================
// clock
`define CLK_MHZ 250

// ========================================
// selection and function command codes
`define CMD_READ_ID 8'h33
`define CMD_MATCH_ID 8'h55
`define CMD_SKIP_SEL 8'hCC
`define CMD_CONVERT 8'h44
`define CMD_SP_READ 8'hBE
`define CMD_SP_WRITE 8'h4E
`define CMD_POWER_Q 8'hB4

// ========================================
// scratchpad layout and reset values
`define SP_UNUSED 8'hFF
`define CFG_ONES 5'h1F
`define RES_RESET 2'h3
`define TEMP_RESET 16'h0000
`define TRIG_RESET 8'h00
`define CRC_POLY_REFL 8'h8C

// ========================================
// link timing, device side
`define T_RSTDET_US 480
`define T_BIT1_MAX_US 15
`define T_TXHOLD_US 30
`define T_PRES_WAIT_US 30
`define T_PRES_US 120
// 62.5 ms, the 9-bit conversion time, kept in microseconds
`define T_CONV9_US 62500
`define RSTDET_CYC (`T_RSTDET_US * `CLK_MHZ)
`define BIT1_MAX_CYC (`T_BIT1_MAX_US * `CLK_MHZ)
`define TXHOLD_CYC (`T_TXHOLD_US * `CLK_MHZ)
`define PRES_WAIT_CYC (`T_PRES_WAIT_US * `CLK_MHZ)
`define PRES_CYC (`T_PRES_US * `CLK_MHZ)
`define CONV9_CYC (`T_CONV9_US * `CLK_MHZ)

// ========================================
// link timing, master side
`define T_MRST_LOW_US 500
`define T_MRST_HIGH_US 480
`define T_PSAMP_US 70
`define T_W1_US 1
`define T_W0_US 60
`define T_RSAMP_US 10
`define T_SLOT_US 70
`define MRST_LOW_CYC (`T_MRST_LOW_US * `CLK_MHZ)
`define MRST_HIGH_CYC (`T_MRST_HIGH_US * `CLK_MHZ)
`define PSAMP_CYC (`T_PSAMP_US * `CLK_MHZ)
`define W1_CYC (`T_W1_US * `CLK_MHZ)
`define W0_CYC (`T_W0_US * `CLK_MHZ)
`define RSAMP_CYC (`T_RSAMP_US * `CLK_MHZ)
`define SLOT_CYC (`T_SLOT_US * `CLK_MHZ)

// ========================================
// master register map and operations
`define REG_CTRL 4'h0
`define REG_DATA 4'h4
`define REG_STATUS 4'h8
`define REG_SPU 4'hC
`define OP_RESET 3'h1
`define OP_WRITE 3'h2
`define OP_READ 3'h3
`define OP_WRITE_SPU 3'h4

`endif

// *** pkg/sensor_pkg.sv ***
// types shared by the sensor device and its bus master
// assumes sensor_consts.svh for all numeric values
package sensor_pkg;

  // ========================================
  // device states
  typedef enum logic [7:0] {
    D_WAIT = 8'h01,
    D_ROM = 8'h02,
    D_MATCH = 8'h04,
    D_FUNC = 8'h08,
    D_WRITE = 8'h10,
    D_SEND = 8'h20,
    D_POWER = 8'h40,
    D_CONV = 8'h80
  } dev_state_e;

  // ========================================
  // master states
  typedef enum logic [3:0] {
    M_IDLE = 4'h1,
    M_RLOW = 4'h2,
    M_RHIGH = 4'h4,
    M_SLOT = 4'h8
  } mst_state_e;

endpackage

// *** pkg/sensor_link_if.sv ***
// open-drain single-wire line between the sensor and its master
// assumes a pull-up: the line is high unless someone drives it low
`timescale 1ns/1ps
`default_nettype none
interface sensor_link_if;
  logic dq;
  logic dq_dev_o;
  logic dq_dev_oe_n;
  logic dq_mst_o;
  logic dq_mst_oe_n;
  logic spu_en;

  // strong pull-up forces the line high
  assign dq = spu_en | ((dq_dev_oe_n | dq_dev_o) & (dq_mst_oe_n | dq_mst_o));

  modport device (input dq, output dq_dev_o, output dq_dev_oe_n);
  modport master (input dq, output dq_mst_o, output dq_mst_oe_n, output spu_en);
endinterface
`default_nettype wire

// *** core/sensor_dev.sv ***
// single-wire temperature sensor slave: selection, scratchpad, conversion
// assumes dq synchronous to clk_sys and a master keeping the slot timing
//
// Functional notes
// - function commands ignored until selection completes
// - master opens with one of five selections; device decodes three (read id, match, skip)
// - after selection accept four function commands
// - convert stores 16-bit sign-extended temperature
// - scratchpad read sends temperature bytes first
// - all bytes travel lsb first
// - resolutions 9 to 12, 12 at reset
// - temperature word follows fixed encoding
// - insignificant low bits forced to zero
// - top five bits copy the sign
// - trigger bytes written and read via scratchpad
// - trigger bytes keep written value
// - power query answers 0 bus, 1 supply
// - master skips, queries power, issues read slots
// - master strong pull-up within 10 us
// - master pulls up through whole conversion if bus-powered
// - 12-bit conversion done within 500 ms
// - skip then convert starts all devices
// - two-bit resolution field, 62.5 to 500 ms
// - ninth byte is crc of eight bytes
// - line low over 480 us resets device
//
// The address map and the plain strobed port were chosen for this implementation.
`include "sensor_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sensor_dev import sensor_pkg::*; #(
  // one scale for all line timing, so the ratios stay intact when shortened
  parameter int unsigned CYC_PER_US = `CLK_MHZ,
  parameter int unsigned RST_CYC = `T_RSTDET_US * CYC_PER_US,
  parameter int unsigned BIT1_MAX_CYC = `T_BIT1_MAX_US * CYC_PER_US,
  parameter int unsigned TXHOLD_CYC = `T_TXHOLD_US * CYC_PER_US,
  parameter int unsigned PRES_WAIT_CYC = `T_PRES_WAIT_US * CYC_PER_US,
  parameter int unsigned PRES_CYC = `T_PRES_US * CYC_PER_US,
  parameter int unsigned CONV9_CYC = `T_CONV9_US * CYC_PER_US,
  // identity is arbitrary
  parameter logic [63:0] ROM_ID = 64'h0123_4567_89AB_CD5A
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // bus line
  sensor_link_if.device lnk,
  // sensor side
  input wire logic [11:0] temp_raw,
  input wire logic supply_powered,
  // status
  output logic [15:0] temp_word,
  output logic conv_busy
);

  // ========================================
  // declarations
  dev_state_e state_reg;
  logic dq_prev_reg;
  logic drv_seen_reg;
  logic oe_n_reg;
  logic match_ok_reg;
  logic conv_busy_reg;
  logic [31:0] low_cnt_reg;
  logic [31:0] pw_cnt_reg;
  logic [31:0] hold_reg;
  logic [31:0] hold_next;
  logic [31:0] conv_cnt_reg;
  logic [6:0] bit_cnt_reg;
  logic [6:0] tx_last_reg;
  logic [7:0] rx_sr_reg;
  logic [7:0] high_trigger_byte_reg;
  logic [7:0] low_trigger_byte_reg;
  logic [1:0] res_reg;
  logic [71:0] tx_sr_reg;
  logic [15:0] temp_reg;
  logic fall;
  logic rise;
  logic long_low;
  logic bit_ev;
  logic bit_val;
  logic byte_done;
  logic id_ok;
  logic tx_on;
  logic tx_bit;
  logic tx_zero;
  logic [7:0] rx_byte;
  logic [7:0] cfg_byte;
  logic [63:0] sp;
  logic [15:0] temp_full;
  logic [15:0] keep_mask;
  logic start_conv;
  logic load_id;
  logic load_sp;

  // reflected shift form of x^8 + x^5 + x^4 + 1
  function automatic logic [7:0] crc8(input logic [63:0] d);
    logic [7:0] c;
    logic fb;
    c = 8'h00;
    for (int i = 0; i < 64; i++) begin
      fb = c[0] ^ d[i];
      c = c >> 1;
      if (fb) begin
        c = c ^ `CRC_POLY_REFL;
      end
    end
    return c;
  endfunction

  // ========================================
  // line events
  assign fall = dq_prev_reg & ~lnk.dq;
  assign rise = ~dq_prev_reg & lnk.dq;
  assign long_low = ~lnk.dq & (low_cnt_reg == RST_CYC - 1);
  // own presence pulse must not count as a bit
  assign bit_ev = rise & (low_cnt_reg != RST_CYC) & ~drv_seen_reg;
  assign bit_val = low_cnt_reg < BIT1_MAX_CYC;
  assign rx_byte = {bit_val, rx_sr_reg[7:1]};
  assign byte_done = bit_cnt_reg[2:0] == 3'h7;
  assign id_ok = ((bit_cnt_reg == 7'h00) | match_ok_reg) & (bit_val == ROM_ID[bit_cnt_reg[5:0]]);

  // ========================================
  // command decode: convert and scratchpad read only after selection, read id in D_ROM
  assign start_conv = bit_ev & (state_reg == D_FUNC) & byte_done & (rx_byte == `CMD_CONVERT);
  assign load_sp = bit_ev & (state_reg == D_FUNC) & byte_done & (rx_byte == `CMD_SP_READ);
  assign load_id = bit_ev & (state_reg == D_ROM) & byte_done & (rx_byte == `CMD_READ_ID);

  // ========================================
  // scratchpad image
  assign cfg_byte = {1'b0, res_reg, `CFG_ONES};
  assign sp = {`SP_UNUSED, `SP_UNUSED, `SP_UNUSED, cfg_byte, low_trigger_byte_reg,
    high_trigger_byte_reg, temp_reg};
  assign temp_full = {{4{temp_raw[11]}}, temp_raw};
  assign keep_mask = 16'hFFFF << (2'h3 - res_reg);

  // ========================================
  // transmit bit selection
  always_comb begin
    tx_on = 1'b1;
    case (state_reg)
      D_SEND: tx_bit = tx_sr_reg[0];
      D_POWER: tx_bit = supply_powered;
      D_CONV: tx_bit = ~conv_busy_reg;
      default: begin
        tx_on = 1'b0;
        tx_bit = 1'b1;
      end
    endcase
  end
  assign tx_zero = fall & tx_on & ~tx_bit;

  // ========================================
  // line sampling and low-time measurement
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dq_prev_reg <= 1'b1;
      low_cnt_reg <= 32'h0000_0000;
    end else begin
      dq_prev_reg <= lnk.dq;
      if (lnk.dq) begin
        low_cnt_reg <= 32'h0000_0000;
      end else if (low_cnt_reg != RST_CYC) begin
        low_cnt_reg <= low_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // ========================================
  // presence pulse and slot hold drive
  always_comb begin
    hold_next = hold_reg - {31'h0000_0000, hold_reg != 32'h0000_0000};
    if (long_low) begin
      hold_next = 32'h0000_0000;
    end else if (pw_cnt_reg == 32'h0000_0001) begin
      hold_next = PRES_CYC;
    end else if (tx_zero) begin
      hold_next = TXHOLD_CYC;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pw_cnt_reg <= 32'h0000_0000;
      hold_reg <= 32'h0000_0000;
      oe_n_reg <= 1'b1;
      drv_seen_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      oe_n_reg <= hold_next == 32'h0000_0000;
      if (long_low) begin
        pw_cnt_reg <= 32'h0000_0000;
      end else if (rise & (low_cnt_reg == RST_CYC)) begin
        pw_cnt_reg <= PRES_WAIT_CYC;
      end else if (pw_cnt_reg != 32'h0000_0000) begin
        pw_cnt_reg <= pw_cnt_reg - 32'h0000_0001;
      end
      if (!oe_n_reg) begin
        drv_seen_reg <= 1'b1;
      end else if (fall) begin
        drv_seen_reg <= 1'b0;
      end
    end
  end

  // ========================================
  // protocol state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= D_WAIT;
      bit_cnt_reg <= 7'h00;
      match_ok_reg <= 1'b0;
    end else if (long_low) begin
      state_reg <= D_ROM;
      bit_cnt_reg <= 7'h00;
    end else if ((state_reg == D_SEND) && fall) begin
      bit_cnt_reg <= bit_cnt_reg + 7'h01;
      if (bit_cnt_reg == tx_last_reg) begin
        state_reg <= D_WAIT;
      end
    end else if (bit_ev) begin
      bit_cnt_reg <= bit_cnt_reg + 7'h01;
      case (state_reg)
        D_ROM: begin
          if (byte_done) begin
            bit_cnt_reg <= 7'h00;
            case (rx_byte)
              `CMD_SKIP_SEL: state_reg <= D_FUNC;
              `CMD_MATCH_ID: state_reg <= D_MATCH;
              `CMD_READ_ID: state_reg <= D_SEND;
              default: state_reg <= D_WAIT;
            endcase
          end
        end
        D_MATCH: begin
          match_ok_reg <= id_ok;
          if (bit_cnt_reg == 7'h3F) begin
            bit_cnt_reg <= 7'h00;
            state_reg <= id_ok ? D_FUNC : D_WAIT;
          end
        end
        D_FUNC: begin
          if (byte_done) begin
            bit_cnt_reg <= 7'h00;
            case (rx_byte)
              `CMD_CONVERT: state_reg <= D_CONV;
              `CMD_SP_READ: state_reg <= D_SEND;
              `CMD_SP_WRITE: state_reg <= D_WRITE;
              `CMD_POWER_Q: state_reg <= D_POWER;
              default: state_reg <= D_WAIT;
            endcase
          end
        end
        D_WRITE: begin
          if (bit_cnt_reg == 7'h17) begin
            state_reg <= D_WAIT;
          end
        end
        default: begin
          bit_cnt_reg <= bit_cnt_reg;
        end
      endcase
    end
  end

  // ========================================
  // receive shifter and scratchpad writes
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_sr_reg <= 8'h00;
      high_trigger_byte_reg <= `TRIG_RESET;
      low_trigger_byte_reg <= `TRIG_RESET;
      res_reg <= `RES_RESET;
    end else if (bit_ev) begin
      rx_sr_reg <= rx_byte;
      if ((state_reg == D_WRITE) && byte_done) begin
        case (bit_cnt_reg[4:3])
          2'h0: high_trigger_byte_reg <= rx_byte;
          2'h1: low_trigger_byte_reg <= rx_byte;
          default: res_reg <= rx_byte[6:5];
        endcase
      end
    end
  end

  // ========================================
  // transmit shifter
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_sr_reg <= {72{1'b1}};
      tx_last_reg <= 7'h00;
    end else if (load_id) begin
      tx_sr_reg <= {`SP_UNUSED, ROM_ID};
      tx_last_reg <= 7'h3F;
    end else if (load_sp) begin
      tx_sr_reg <= {crc8(sp), sp};
      tx_last_reg <= 7'h47;
    end else if ((state_reg == D_SEND) && fall) begin
      tx_sr_reg <= {1'b1, tx_sr_reg[71:1]};
    end
  end

  // ========================================
  // conversion timer, longer at finer resolution
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      conv_cnt_reg <= 32'h0000_0000;
      conv_busy_reg <= 1'b0;
      temp_reg <= `TEMP_RESET;
    end else if (start_conv) begin
      conv_cnt_reg <= CONV9_CYC << res_reg;
      conv_busy_reg <= 1'b1;
    end else if (conv_cnt_reg == 32'h0000_0001) begin
      conv_cnt_reg <= 32'h0000_0000;
      conv_busy_reg <= 1'b0;
      temp_reg <= temp_full & keep_mask;
    end else if (conv_cnt_reg != 32'h0000_0000) begin
      conv_cnt_reg <= conv_cnt_reg - 32'h0000_0001;
    end
  end

  // ========================================
  // outputs
  assign lnk.dq_dev_o = 1'b0;
  assign lnk.dq_dev_oe_n = oe_n_reg;
  assign temp_word = temp_reg;
  assign conv_busy = conv_busy_reg;

endmodule
`default_nettype wire

// *** core/sensor_mst.sv ***
// single-wire bus master: reset, byte write, byte read, strong pull-up
// assumes software through a plain register port, one device or more on the line
`include "sensor_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sensor_mst import sensor_pkg::*; #(
  // one scale for all slot timing, so the ratios stay intact when shortened
  parameter int unsigned CYC_PER_US = `CLK_MHZ,
  parameter int unsigned RST_LOW_CYC = `T_MRST_LOW_US * CYC_PER_US,
  parameter int unsigned RST_HIGH_CYC = `T_MRST_HIGH_US * CYC_PER_US,
  parameter int unsigned PSAMP_CYC = `T_PSAMP_US * CYC_PER_US,
  parameter int unsigned W1_CYC = `T_W1_US * CYC_PER_US,
  parameter int unsigned W0_CYC = `T_W0_US * CYC_PER_US,
  parameter int unsigned RSAMP_CYC = `T_RSAMP_US * CYC_PER_US,
  parameter int unsigned SLOT_CYC = `T_SLOT_US * CYC_PER_US
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // bus line
  sensor_link_if.master lnk,
  // register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata
);

  // ========================================
  // declarations
  mst_state_e st_reg;
  logic [31:0] tmr_reg;
  logic [2:0] bit_idx_reg;
  logic [7:0] sh_reg;
  logic rd_op_reg;
  logic spu_after_reg;
  logic spu_reg;
  logic pres_reg;
  logic oe_n_reg;
  logic [31:0] rdata_reg;
  logic busy;
  logic go;
  logic slot_end;
  logic spu_go;
  logic [31:0] low_len;

  assign busy = st_reg != M_IDLE;
  // operations while busy are dropped
  assign go = wr_stb & (addr == `REG_CTRL) & ~busy;
  assign slot_end = (st_reg == M_SLOT) & (tmr_reg == SLOT_CYC - 1);
  assign spu_go = slot_end & (bit_idx_reg == 3'h7) & spu_after_reg;
  assign low_len = (rd_op_reg | sh_reg[0]) ? W1_CYC : W0_CYC;

  // ========================================
  // sequencer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_reg <= M_IDLE;
      tmr_reg <= 32'h0000_0000;
      bit_idx_reg <= 3'h0;
      sh_reg <= 8'h00;
      rd_op_reg <= 1'b0;
      spu_after_reg <= 1'b0;
      pres_reg <= 1'b0;
    end else begin
      tmr_reg <= tmr_reg + 32'h0000_0001;
      case (st_reg)
        M_IDLE: begin
          tmr_reg <= 32'h0000_0000;
          bit_idx_reg <= 3'h0;
          if (wr_stb && (addr == `REG_DATA)) begin
            sh_reg <= wdata[7:0];
          end
          if (go) begin
            rd_op_reg <= wdata[2:0] == `OP_READ;
            spu_after_reg <= wdata[2:0] == `OP_WRITE_SPU;
            case (wdata[2:0])
              `OP_RESET: st_reg <= M_RLOW;
              `OP_WRITE, `OP_READ, `OP_WRITE_SPU: st_reg <= M_SLOT;
              default: st_reg <= M_IDLE;
            endcase
          end
        end
        M_RLOW: begin
          if (tmr_reg == RST_LOW_CYC - 1) begin
            tmr_reg <= 32'h0000_0000;
            st_reg <= M_RHIGH;
          end
        end
        M_RHIGH: begin
          if (tmr_reg == PSAMP_CYC) begin
            pres_reg <= ~lnk.dq;
          end
          if (tmr_reg == RST_HIGH_CYC - 1) begin
            st_reg <= M_IDLE;
          end
        end
        M_SLOT: begin
          if (rd_op_reg && (tmr_reg == RSAMP_CYC)) begin
            sh_reg <= {lnk.dq, sh_reg[7:1]};
          end
          if (slot_end) begin
            tmr_reg <= 32'h0000_0000;
            bit_idx_reg <= bit_idx_reg + 3'h1;
            if (!rd_op_reg) begin
              sh_reg <= {1'b0, sh_reg[7:1]};
            end
            if (bit_idx_reg == 3'h7) begin
              st_reg <= M_IDLE;
            end
          end
        end
        default: st_reg <= M_IDLE;
      endcase
    end
  end

  // ========================================
  // strong pull-up: on at the end of the command byte, off by software
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      spu_reg <= 1'b0;
    end else if (spu_go) begin
      spu_reg <= 1'b1;
    end else if (go) begin
      spu_reg <= 1'b0;
    end else if (wr_stb && (addr == `REG_SPU)) begin
      spu_reg <= wdata[0];
    end
  end

  // ========================================
  // line drive, one cycle behind the sequencer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      oe_n_reg <= 1'b1;
    end else begin
      oe_n_reg <= ~((st_reg == M_RLOW) | ((st_reg == M_SLOT) & (tmr_reg < low_len)));
    end
  end

  // ========================================
  // register read, data valid for one cycle only
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_stb) begin
      case (addr)
        `REG_DATA: rdata_reg <= {24'h00_0000, sh_reg};
        `REG_STATUS: rdata_reg <= {29'h0000_0000, spu_reg, pres_reg, busy};
        `REG_SPU: rdata_reg <= {31'h0000_0000, spu_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign lnk.dq_mst_o = 1'b0;
  assign lnk.dq_mst_oe_n = oe_n_reg;
  assign lnk.spu_en = spu_reg;
  assign rdata = rdata_reg;

endmodule
`default_nettype wire

// *** sim/sensor_link_checker.sv ***
// checker for the single-wire line between master and sensor
// assumes the shortened link timing; takes the interface signals as inputs
`timescale 1ns/1ps
`default_nettype none
module sensor_link_checker #(
  parameter int TXHOLD_CYC = 30,
  parameter int PRES_CYC = 120,
  parameter int W1_CYC = 2,
  parameter int W0_CYC = 60,
  parameter int RST_LOW_CYC = 500,
  parameter int SLOT_CYC = 70
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // line
  input wire logic dq,
  input wire logic dq_dev_o,
  input wire logic dq_dev_oe_n,
  input wire logic dq_mst_o,
  input wire logic dq_mst_oe_n,
  input wire logic spu_en
);
  // ====================
  // low-time and gap counters
  logic [9:0] dcnt;
  logic [9:0] mcnt;
  logic [15:0] gcnt;
  logic [15:0] rcnt;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dcnt <= 10'h0;
      mcnt <= 10'h0;
    end else begin
      dcnt <= dq_dev_oe_n ? 10'h0 : dcnt + 10'h1;
      mcnt <= dq_mst_oe_n ? 10'h0 : mcnt + 10'h1;
    end
  end

  // saturating, so a long idle never wraps into a short gap
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gcnt <= 16'hFFFF;
      rcnt <= 16'hFFFF;
    end else begin
      gcnt <= $fell(dq_mst_oe_n) ? 16'h0 : gcnt + {15'h0, gcnt != 16'hFFFF};
      rcnt <= $rose(dq_mst_oe_n) ? 16'h0 : rcnt + {15'h0, rcnt != 16'hFFFF};
    end
  end

  // ====================
  // assertions
  a_dev_open_drain: assert property (!dq_dev_oe_n |-> !dq_dev_o)
    else $error("device drives the line high");
  a_mst_open_drain: assert property (!dq_mst_oe_n |-> !dq_mst_o)
    else $error("master drives the line high");
  a_spu_line_free: assert property (spu_en |-> dq && dq_mst_oe_n && dq_dev_oe_n)
    else $error("line pulled low under strong pull-up");
  a_spu_prompt: assert property ($rose(spu_en) |-> rcnt < 16)
    else $error("strong pull-up late after command");
  a_presence_seq: assert property ($rose(dq_mst_oe_n) && mcnt >= RST_LOW_CYC - 2
    |-> dq_dev_oe_n [*8] ##[20:34] !dq_dev_oe_n)
    else $error("no presence after bus reset");
  a_dev_hold_len: assert property ($rose(dq_dev_oe_n) |-> dcnt inside
    {[TXHOLD_CYC - 1:TXHOLD_CYC + 1], [PRES_CYC - 1:PRES_CYC + 1]})
    else $error("device low time wrong");
  a_mst_low_len: assert property ($rose(dq_mst_oe_n) |-> mcnt inside
    {[W1_CYC - 1:W1_CYC + 1], [W0_CYC - 1:W0_CYC + 1], [RST_LOW_CYC - 1:RST_LOW_CYC + 1]})
    else $error("master low time wrong");
  a_slot_gap: assert property ($fell(dq_mst_oe_n) |-> gcnt >= SLOT_CYC - 2)
    else $error("slots too close");

  c_bus_reset: cover property ($rose(dq_mst_oe_n) && mcnt >= RST_LOW_CYC - 2);
  c_zero_bit: cover property ($rose(dq_dev_oe_n) && dcnt < 40);
  c_pull_up: cover property ($rose(spu_en));
endmodule
`default_nettype wire

// *** sim/single_wire_temp_sensor_slave_bench.sv ***
// bench: master and sensor joined by the line, driven through the register port
// assumes the shortened timing, one clock cycle standing for one microsecond
`include "sensor_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module single_wire_temp_sensor_slave_bench;
  // ====================
  // signals and case tables
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rdata;
  logic [11:0] temp_raw = 12'h000;
  logic supply_powered = 1'b1;
  logic [15:0] temp_word;
  logic conv_busy;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] s;
  logic [1:0] cr [5] = '{2'h3, 2'h3, 2'h0, 2'h1, 2'h2};
  logic [11:0] cw [5] = '{12'h7D0, 12'hFF8, 12'h191, 12'hE6F, 12'h191};
  logic [15:0] ce [5] = '{16'h07D0, 16'hFFF8, 16'h0190, 16'hFE6C, 16'h0190};
  logic [7:0] sc [4] = '{`CMD_SP_READ, 8'hF0, 8'hEC, `CMD_READ_ID};
  // last entry is the low byte of the default identity
  logic [7:0] se [4] = '{8'hFF, 8'hFF, 8'hFF, 8'h5A};
  // default identity of the sensor, value arbitrary
  logic [63:0] rid = 64'h0123_4567_89AB_CD5A;

  always #2 clk_sys = ~clk_sys;

  sensor_link_if lnk();
  sensor_dev #(.CYC_PER_US(1), .CONV9_CYC(100)) u_sensor_dev (
    .clk_sys(clk_sys), .rstn(rstn), .lnk(lnk), .temp_raw(temp_raw),
    .supply_powered(supply_powered), .temp_word(temp_word), .conv_busy(conv_busy));
  sensor_mst #(.CYC_PER_US(1), .W1_CYC(2)) u_sensor_mst (
    .clk_sys(clk_sys), .rstn(rstn), .lnk(lnk), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));
  sensor_link_checker u_sensor_link_checker (
    .clk_sys(clk_sys), .rstn(rstn), .dq(lnk.dq), .dq_dev_o(lnk.dq_dev_o),
    .dq_dev_oe_n(lnk.dq_dev_oe_n), .dq_mst_o(lnk.dq_mst_o),
    .dq_mst_oe_n(lnk.dq_mst_oe_n), .spu_en(lnk.spu_en));

  // ====================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    // idle edge, so a following write never re-raises the strobe in this step
    @(posedge clk_sys);
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1 v = rdata;
    @(posedge clk_sys);
  endtask

  task automatic op(input logic [2:0] c, input logic [7:0] b);
    logic [31:0] v;
    int n;
    wr(`REG_DATA, {24'h0, b});
    wr(`REG_CTRL, {29'h0, c});
    repeat (2) @(posedge clk_sys);
    n = 0;
    v = 32'h1;
    while (v[0] !== 1'b0 && n < 2000) begin
      rd(`REG_STATUS, v);
      n++;
    end
    chk(v & 32'h1, 32'h0);
  endtask

  task automatic rb(input logic [7:0] e);
    logic [31:0] v;
    op(`OP_READ, 8'hFF);
    rd(`REG_DATA, v);
    chk(v & 32'hFF, {24'h0, e});
  endtask

  task automatic sel();
    op(`OP_RESET, 8'h00);
    op(`OP_WRITE, `CMD_SKIP_SEL);
  endtask

  task automatic cfg(input logic [1:0] r);
    sel();
    op(`OP_WRITE, `CMD_SP_WRITE);
    op(`OP_WRITE, 8'h55);
    op(`OP_WRITE, 8'hAA);
    op(`OP_WRITE, {1'b0, r, 5'h1F});
  endtask

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ b[i]) ? ((c >> 1) ^ `CRC_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction

  task automatic sp(input logic [15:0] t, input logic [1:0] r);
    logic [7:0] b [9];
    b = '{t[7:0], t[15:8], 8'h55, 8'hAA, {1'b0, r, 5'h1F}, 8'hFF, 8'hFF, 8'hFF, 8'h00};
    for (int i = 0; i < 8; i++) begin
      b[8] = crc8(b[8], b[i]);
    end
    sel();
    op(`OP_WRITE, `CMD_SP_READ);
    for (int i = 0; i < 9; i++) begin
      rb(b[i]);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ceiling well above the expected run of about 83k cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 95000) begin
      err_total++;
      end_of_test();
    end
  end

  // ====================
  // sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk({16'h0, temp_word}, 32'h0);
    chk({31'h0, conv_busy}, 32'h0);
    rd(4'h2, s);
    chk(s, 32'h0);
    op(`OP_RESET, 8'h00);
    rd(`REG_STATUS, s);
    chk(s & 32'h2, 32'h2);
    for (int i = 0; i < 4; i++) begin
      op(`OP_RESET, 8'h00);
      op(`OP_WRITE, sc[i]);
      rb(se[i]);
    end
    op(`OP_RESET, 8'h00);
    op(`OP_WRITE, `CMD_MATCH_ID);
    for (int k = 0; k < 8; k++) begin
      op(`OP_WRITE, rid[8*k +: 8]);
    end
    op(`OP_WRITE, `CMD_SP_READ);
    rb(8'h00);
    for (int i = 0; i < 2; i++) begin
      supply_powered <= i[0];
      sel();
      op(`OP_WRITE, `CMD_POWER_Q);
      rb(i[0] ? 8'hFF : 8'h00);
    end
    for (int i = 0; i < 5; i++) begin
      int n;
      cfg(cr[i]);
      temp_raw <= cw[i];
      sel();
      op(`OP_WRITE_SPU, `CMD_CONVERT);
      rd(`REG_STATUS, s);
      chk(s & 32'h4, 32'h4);
      wr(`REG_SPU, 32'h0);
      n = 0;
      while (conv_busy !== 1'b0 && n < 1000) begin
        @(posedge clk_sys);
        n++;
      end
      chk(32'(n <= (100 << cr[i])), 32'h1);
      chk({16'h0, temp_word}, {16'h0, ce[i]});
      if (i != 1) begin
        sp(ce[i], cr[i]);
      end
    end
    end_of_test();
  end
endmodule
`default_nettype wire
